// >>> hdl/xirq_dest_match.sv
// One destination's physical or logical address match
`timescale 1ns/100ps
module xirq_dest_match (
  // Packet fields
  input  wire logic        i_dm,
  input  wire logic [31:0] i_dest,
  // This destination's identities
  input  wire logic [7:0]  i_phys_id,
  input  wire logic [31:0] i_log_id,
  // Result
  output logic             o_hit
);

  // Physical: exact id or broadcast; logical: one-hot style overlap
  always_comb begin
    if (!i_dm) begin
      o_hit = (i_dest[7:0] == i_phys_id) ||
              (i_dest[7:0] == xirq_pkg::PHYS_BCAST);
    end else begin
      o_hit = |(i_dest & i_log_id);
    end
  end

endmodule

// >>> hdl/xirq_pkg.sv
// Constants and types shared by the interrupt request receiver
package xirq_pkg;

  // Packet framing: bit-times, control-flag boundary, byte slots
  localparam int         NUM_BT      = 12;
  localparam int         CTL_BT      = 8;
  localparam logic [3:0] BT_LAST     = 4'hb;
  localparam logic [3:0] BT_CTL_LAST = 4'h7;
  localparam int BT_CMD  = 0;
  localparam int BT_UNIT = 1;
  localparam int BT_TYPE = 3;
  localparam int BT_DST0 = 4;
  localparam int BT_VEC  = 5;
  localparam int BT_ADL  = 6;
  localparam int BT_ADH  = 7;
  localparam int BT_DST1 = 8;
  localparam int BT_DST2 = 9;
  localparam int BT_DST3 = 10;

  // Field positions inside the type byte and the unit byte
  localparam int B3_MT3  = 7;
  localparam int B3_DM   = 6;
  localparam int B3_LVL  = 5;
  localparam int B3_MTHI = 4;
  localparam int B3_MTLO = 2;
  localparam int B1_UNHI = 4;

  // Command 1010X1: bit 1 is a don't-care
  localparam logic [5:0]  CMD_VAL     = 6'h29;
  localparam logic [5:0]  CMD_MASK    = 6'h3d;
  localparam logic [15:0] ADDR_PREFIX = 16'hfdf8;
  localparam logic [7:0]  PHYS_BCAST  = 8'hff;
  localparam logic [7:0]  NONVEC_VEC  = 8'h00;

  // Message type codes
  localparam logic [3:0] MT_FIXED  = 4'h0;
  localparam logic [3:0] MT_ARB    = 4'h1;
  localparam logic [3:0] MT_SMI    = 4'h2;
  localparam logic [3:0] MT_NMI    = 4'h3;
  localparam logic [3:0] MT_INIT   = 4'h4;
  localparam logic [3:0] MT_START  = 4'h5;
  localparam logic [3:0] MT_EXTERNAL_PIC_INTERRUPT = 4'h6;
  localparam logic [3:0] MT_LNMI   = 4'hb;
  localparam logic [3:0] MT_LEXT   = 4'he;

  typedef enum logic [1:0] {
    CLS_FIXED  = 2'h0,
    CLS_ARB    = 2'h1,
    CLS_NONVEC = 2'h2,
    CLS_BAD    = 2'h3
  } xirq_class_t;

  typedef enum logic [1:0] {
    ST_HEAD = 2'h0,
    ST_TAIL = 2'h1,
    ST_EVAL = 2'h3
  } xirq_state_t;

  // Register map (byte addresses), per-destination banks of 4 words
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_LAST   = 12'h008;
  localparam logic [11:0] OFF_COUNT  = 12'h00c;
  localparam logic [11:0] OFF_PHYS   = 12'h010;
  localparam logic [11:0] OFF_LOG    = 12'h020;
  localparam logic [11:0] OFF_PRIO   = 12'h030;
  localparam logic [11:0] OFF_DEST   = 12'h040;

  // Control and status bits
  localparam int          CTRL_EN    = 0;
  localparam int          CTRL_CHK   = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h3;
  localparam int          ST_W       = 6;
  localparam int          ERR_FRAME  = 0;
  localparam int          ERR_CMD    = 1;
  localparam int          ERR_PREFIX = 2;
  localparam int          ERR_TYPE   = 3;
  localparam int          ERR_DEST   = 4;
  localparam int          ERR_MIX    = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> hdl/xirq_receiver.sv
// Interrupt request packet receiver with AXI4-Lite register file
`timescale 1ns/100ps
// Function
// - Twelve bit-times; first eight carry control flag
// - Address bits 39:24 must read FDF8h
// - Classify: arbitrated, fixed or non-vectored
// - Arbitrated goes to at most one target, none when no target matches
// - Eight-bit vector names the source
// - Fixed goes to every addressed target
// - Targets from destination field and mode bit
// - Physical: low byte, FFh broadcasts; logical: 32-bit
// - Trigger bit: 0 edge, 1 level; unshared vectors
module xirq_receiver #(
  parameter int NUM_DEST = 4
) (
  // Clock, reset, enable
  input  wire logic                i_mclk,
  input  wire logic                i_reset,
  input  wire logic                i_ce,
  // Packet link, one bit-time per beat
  input  wire logic                i_link_valid,
  input  wire logic                i_link_ctl,
  input  wire logic [7:0]          i_link_data,
  output logic                     o_link_ready,
  // Delivery
  output logic                     o_irq_valid,
  output logic [NUM_DEST-1:0]      o_irq_targets,
  output logic [7:0]               o_irq_vector,
  output logic [1:0]               o_irq_class,
  output logic                     o_irq_level,
  output logic [3:0]               o_irq_msg_type,
  output logic [4:0]               o_irq_unit,
  // AXI4-Lite write
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [11:0]         s_axi_araddr,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp
);

  localparam int VW = 256;

  // Packet and delivery state
  xirq_pkg::xirq_state_t state_r, state_nxt;
  logic [3:0]            bt_r, bt_nxt;
  logic [7:0]            pkt_r [xirq_pkg::NUM_BT];
  logic [7:0]            pkt_nxt [xirq_pkg::NUM_BT];
  logic                  ready_r, ready_nxt, val_r, val_nxt, lvl_r, lvl_nxt;
  logic [NUM_DEST-1:0]   tgt_r, tgt_nxt;
  logic [7:0]            vec_r, vec_nxt;
  logic [1:0]            cls_r, cls_nxt;
  logic [3:0]            mt_r, mt_nxt;
  logic [4:0]            unit_r, unit_nxt;
  logic                  dm_r, dm_nxt;
  logic [31:0]           dst_r, dst_nxt;
  logic [VW-1:0]         seen_r, seen_nxt, vlvl_r, vlvl_nxt;
  logic [7:0]            fvec_r [NUM_DEST];
  logic [7:0]            fvec_nxt [NUM_DEST];
  logic [NUM_DEST-1:0]   fval_r, fval_nxt;
  logic [xirq_pkg::ST_W-1:0] err_set;

  // Register file state
  logic [1:0]            ctrl_r, ctrl_nxt;
  logic [xirq_pkg::ST_W-1:0] stat_r, stat_nxt;
  logic [31:0]           cnt_r, cnt_nxt;
  logic [7:0]            phys_r [NUM_DEST];
  logic [7:0]            phys_nxt [NUM_DEST];
  logic [31:0]           log_r [NUM_DEST];
  logic [31:0]           log_nxt [NUM_DEST];
  logic [7:0]            prio_r [NUM_DEST];
  logic [7:0]            prio_nxt [NUM_DEST];
  logic                  awf_r, awf_nxt, wf_r, wf_nxt;
  logic [11:0]           awa_r, awa_nxt;
  logic [31:0]           wd_r, wd_nxt;
  logic [3:0]            ws_r, ws_nxt;
  logic                  awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic                  bv_r, bv_nxt, arrdy_r, arrdy_nxt, rv_r, rv_nxt;
  logic [1:0]            br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0]           rd_r, rd_nxt;

  // Decoded packet fields, live while the packet is held
  logic [5:0]            f_cmd;
  logic [3:0]            f_mt;
  logic                  f_dm, f_lvl;
  logic [7:0]            f_vec;
  logic [31:0]           f_dst;
  logic [15:0]           f_pfx;
  logic [NUM_DEST-1:0]   hit;
  xirq_pkg::xirq_class_t f_cls;

  // Reserved slots (count byte low bits, last tail byte) are never read
  assign f_cmd = pkt_r[xirq_pkg::BT_CMD][5:0];
  assign f_mt  = {pkt_r[xirq_pkg::BT_TYPE][xirq_pkg::B3_MT3],
                  pkt_r[xirq_pkg::BT_TYPE][xirq_pkg::B3_MTHI:xirq_pkg::B3_MTLO]};
  assign f_dm  = pkt_r[xirq_pkg::BT_TYPE][xirq_pkg::B3_DM];
  assign f_lvl = pkt_r[xirq_pkg::BT_TYPE][xirq_pkg::B3_LVL];
  assign f_vec = pkt_r[xirq_pkg::BT_VEC];
  assign f_dst = {pkt_r[xirq_pkg::BT_DST3], pkt_r[xirq_pkg::BT_DST2],
                  pkt_r[xirq_pkg::BT_DST1], pkt_r[xirq_pkg::BT_DST0]};
  assign f_pfx = {pkt_r[xirq_pkg::BT_ADH], pkt_r[xirq_pkg::BT_ADL]};

  // Per-destination match from field and mode bit
  for (genvar g = 0; g < NUM_DEST; g++) begin : g_match
    xirq_dest_match u_match (
      .i_dm      (f_dm),
      .i_dest    (f_dst),
      .i_phys_id (phys_r[g]),
      .i_log_id  (log_r[g]),
      .o_hit     (hit[g])
    );
  end

  // Message type to class; startup carries a vector like fixed
  always_comb begin
    unique case (f_mt)
      xirq_pkg::MT_FIXED, xirq_pkg::MT_START: f_cls = xirq_pkg::CLS_FIXED;
      xirq_pkg::MT_ARB:    f_cls = xirq_pkg::CLS_ARB;
      xirq_pkg::MT_SMI, xirq_pkg::MT_NMI, xirq_pkg::MT_INIT,
      xirq_pkg::MT_EXTERNAL_PIC_INTERRUPT, xirq_pkg::MT_LNMI,
      xirq_pkg::MT_LEXT:   f_cls = xirq_pkg::CLS_NONVEC;
      default:             f_cls = xirq_pkg::CLS_BAD;
    endcase
  end

  // Framing, checking, target choice
  always_comb begin
    logic                 exp_ctl, focus_any, ok;
    logic [NUM_DEST-1:0]  pick;
    logic [7:0]           best;
    exp_ctl   = (state_r == xirq_pkg::ST_HEAD);
    focus_any = 1'b0;
    ok        = 1'b0;
    pick      = '0;
    best      = 8'hff;
    state_nxt = state_r;
    bt_nxt    = bt_r;
    pkt_nxt   = pkt_r;
    val_nxt   = 1'b0;
    tgt_nxt   = tgt_r;
    vec_nxt   = vec_r;
    cls_nxt   = cls_r;
    lvl_nxt   = lvl_r;
    mt_nxt    = mt_r;
    unit_nxt  = unit_r;
    dm_nxt    = dm_r;
    dst_nxt   = dst_r;
    seen_nxt  = seen_r;
    vlvl_nxt  = vlvl_r;
    fvec_nxt  = fvec_r;
    fval_nxt  = fval_r;
    err_set   = '0;
    unique case (state_r)
      xirq_pkg::ST_HEAD, xirq_pkg::ST_TAIL: begin
        if (i_link_valid && ready_r) begin
          if (i_link_ctl != exp_ctl) begin
            // Misframed beat: drop the partial packet, resync at head
            err_set[xirq_pkg::ERR_FRAME] = 1'b1;
            state_nxt = xirq_pkg::ST_HEAD;
            bt_nxt    = '0;
          end else begin
            pkt_nxt[bt_r] = i_link_data;
            bt_nxt        = bt_r + 4'h1;
            if (bt_r == xirq_pkg::BT_CTL_LAST) begin
              state_nxt = xirq_pkg::ST_TAIL;
            end
            if (bt_r == xirq_pkg::BT_LAST) begin
              state_nxt = xirq_pkg::ST_EVAL;
              bt_nxt    = '0;
            end
          end
        end
      end
      xirq_pkg::ST_EVAL: begin
        state_nxt = xirq_pkg::ST_HEAD;
        err_set[xirq_pkg::ERR_CMD] =
          (f_cmd & xirq_pkg::CMD_MASK) != xirq_pkg::CMD_VAL;
        err_set[xirq_pkg::ERR_PREFIX] = ctrl_r[xirq_pkg::CTRL_CHK] &&
          (f_pfx != xirq_pkg::ADDR_PREFIX);
        err_set[xirq_pkg::ERR_TYPE] = (f_cls == xirq_pkg::CLS_BAD) ||
          ((f_cls == xirq_pkg::CLS_NONVEC) &&
           ((f_vec != xirq_pkg::NONVEC_VEC) || f_lvl));
        err_set[xirq_pkg::ERR_DEST] = !f_dm && (f_dst[31:8] != '0);
        err_set[xirq_pkg::ERR_MIX] = (f_cls != xirq_pkg::CLS_NONVEC) &&
          seen_r[f_vec] && (vlvl_r[f_vec] != f_lvl);
        ok = ctrl_r[xirq_pkg::CTRL_EN] && (err_set == '0);
        // Focus processor first, else lowest priority value
        for (int i = 0; i < NUM_DEST; i++) begin
          if (!focus_any && hit[i] && fval_r[i] && fvec_r[i] == f_vec) begin
            focus_any = 1'b1;
            pick      = '0;
            pick[i]   = 1'b1;
          end
        end
        for (int i = 0; i < NUM_DEST; i++) begin
          if (!focus_any && hit[i] && (pick == '0 || prio_r[i] < best)) begin
            best    = prio_r[i];
            pick    = '0;
            pick[i] = 1'b1;
          end
        end
        if (ok) begin
          val_nxt  = 1'b1;
          tgt_nxt  = (f_cls == xirq_pkg::CLS_ARB) ? pick : hit;
          vec_nxt  = f_vec;
          cls_nxt  = f_cls;
          lvl_nxt  = f_lvl;
          mt_nxt   = f_mt;
          unit_nxt = pkt_r[xirq_pkg::BT_UNIT][xirq_pkg::B1_UNHI:0];
          dm_nxt   = f_dm;
          dst_nxt  = f_dst;
          if (f_cls != xirq_pkg::CLS_NONVEC) begin
            seen_nxt[f_vec] = 1'b1;
            vlvl_nxt[f_vec] = f_lvl;
          end
          for (int i = 0; i < NUM_DEST; i++) begin
            if (f_cls == xirq_pkg::CLS_ARB && pick[i]) begin
              fval_nxt[i] = 1'b1;
              fvec_nxt[i] = f_vec;
            end
          end
        end
      end
      default: begin
        state_nxt = xirq_pkg::ST_HEAD;
        bt_nxt    = '0;
      end
    endcase
    ready_nxt = (state_nxt != xirq_pkg::ST_EVAL);
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= xirq_pkg::ST_HEAD;
      bt_r    <= '0;
      pkt_r   <= '{default: '0};
      ready_r <= 1'b0;
      val_r   <= 1'b0;
      tgt_r   <= '0;
      vec_r   <= '0;
      cls_r   <= '0;
      lvl_r   <= 1'b0;
      mt_r    <= '0;
      unit_r  <= '0;
      dm_r    <= 1'b0;
      dst_r   <= '0;
      seen_r  <= '0;
      vlvl_r  <= '0;
      fvec_r  <= '{default: '0};
      fval_r  <= '0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      bt_r    <= bt_nxt;
      pkt_r   <= pkt_nxt;
      ready_r <= ready_nxt;
      val_r   <= val_nxt;
      tgt_r   <= tgt_nxt;
      vec_r   <= vec_nxt;
      cls_r   <= cls_nxt;
      lvl_r   <= lvl_nxt;
      mt_r    <= mt_nxt;
      unit_r  <= unit_nxt;
      dm_r    <= dm_nxt;
      dst_r   <= dst_nxt;
      seen_r  <= seen_nxt;
      vlvl_r  <= vlvl_nxt;
      fvec_r  <= fvec_nxt;
      fval_r  <= fval_nxt;
    end
  end

  // Byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction

  // Bus slave; address and data latch in either order, one at a time
  always_comb begin
    logic        hit_w, hit_r;
    logic [31:0] word;
    logic [1:0]  idx;
    hit_w    = 1'b0;
    hit_r    = 1'b0;
    word     = '0;
    idx      = '0;
    ctrl_nxt = ctrl_r;
    phys_nxt = phys_r;
    log_nxt  = log_r;
    prio_nxt = prio_r;
    awf_nxt  = awf_r;
    awa_nxt  = awa_r;
    wf_nxt   = wf_r;
    wd_nxt   = wd_r;
    ws_nxt   = ws_r;
    bv_nxt   = bv_r && !s_axi_bready;
    br_nxt   = br_r;
    rv_nxt   = rv_r && !s_axi_rready;
    rr_nxt   = rr_r;
    rd_nxt   = rd_r;
    stat_nxt = stat_r;
    cnt_nxt  = val_r ? cnt_r + 32'h1 : cnt_r;
    if (s_axi_awvalid && awrdy_r) begin
      awf_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_r) begin
      wf_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (awf_r && wf_r && !bv_r) begin
      idx   = awa_r[3:2];
      hit_w = 1'b1;
      if (awa_r == xirq_pkg::OFF_CTRL) begin
        word     = merge({30'h0, ctrl_r}, wd_r, ws_r);
        ctrl_nxt = word[1:0];
      end else if (awa_r == xirq_pkg::OFF_STATUS) begin
        if (ws_r[0]) stat_nxt = stat_r & ~wd_r[xirq_pkg::ST_W-1:0];
      end else if (32'(idx) < NUM_DEST &&
                   awa_r[11:4] == xirq_pkg::OFF_PHYS[11:4]) begin
        word          = merge({24'h0, phys_r[idx]}, wd_r, ws_r);
        phys_nxt[idx] = word[7:0];
      end else if (32'(idx) < NUM_DEST &&
                   awa_r[11:4] == xirq_pkg::OFF_LOG[11:4]) begin
        log_nxt[idx]  = merge(log_r[idx], wd_r, ws_r);
      end else if (32'(idx) < NUM_DEST &&
                   awa_r[11:4] == xirq_pkg::OFF_PRIO[11:4]) begin
        word          = merge({24'h0, prio_r[idx]}, wd_r, ws_r);
        prio_nxt[idx] = word[7:0];
      end else begin
        hit_w = 1'b0;
      end
      awf_nxt = 1'b0;
      wf_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = hit_w ? xirq_pkg::RESP_OKAY : xirq_pkg::RESP_SLVERR;
    end
    // Hardware errors set after the clear so a coincident event survives
    stat_nxt = stat_nxt | err_set;
    if (s_axi_arvalid && arrdy_r) begin
      idx   = s_axi_araddr[3:2];
      hit_r = 1'b1;
      word  = '0;
      if (s_axi_araddr == xirq_pkg::OFF_CTRL) word = {30'h0, ctrl_r};
      else if (s_axi_araddr == xirq_pkg::OFF_STATUS) word = 32'(stat_r);
      else if (s_axi_araddr == xirq_pkg::OFF_LAST)
        word = {11'h0, unit_r, lvl_r, dm_r, cls_r, mt_r, vec_r};
      else if (s_axi_araddr == xirq_pkg::OFF_COUNT) word = cnt_r;
      else if (s_axi_araddr == xirq_pkg::OFF_DEST) word = dst_r;
      else if (32'(idx) < NUM_DEST &&
               s_axi_araddr[11:4] == xirq_pkg::OFF_PHYS[11:4])
        word = {24'h0, phys_r[idx]};
      else if (32'(idx) < NUM_DEST &&
               s_axi_araddr[11:4] == xirq_pkg::OFF_LOG[11:4])
        word = log_r[idx];
      else if (32'(idx) < NUM_DEST &&
               s_axi_araddr[11:4] == xirq_pkg::OFF_PRIO[11:4])
        word = {24'h0, prio_r[idx]};
      else hit_r = 1'b0;
      rv_nxt = 1'b1;
      rd_nxt = word;
      rr_nxt = hit_r ? xirq_pkg::RESP_OKAY : xirq_pkg::RESP_SLVERR;
    end
    awrdy_nxt = !awf_nxt && !bv_nxt;
    wrdy_nxt  = !wf_nxt && !bv_nxt;
    arrdy_nxt = !rv_nxt;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r  <= xirq_pkg::CTRL_RST;
      stat_r  <= '0;
      cnt_r   <= '0;
      phys_r  <= '{default: '0};
      log_r   <= '{default: '0};
      prio_r  <= '{default: '0};
      awf_r   <= 1'b0;
      awa_r   <= '0;
      wf_r    <= 1'b0;
      wd_r    <= '0;
      ws_r    <= '0;
      awrdy_r <= 1'b0;
      wrdy_r  <= 1'b0;
      bv_r    <= 1'b0;
      br_r    <= '0;
      arrdy_r <= 1'b0;
      rv_r    <= 1'b0;
      rr_r    <= '0;
      rd_r    <= '0;
    end else if (i_ce) begin
      ctrl_r  <= ctrl_nxt;
      stat_r  <= stat_nxt;
      cnt_r   <= cnt_nxt;
      phys_r  <= phys_nxt;
      log_r   <= log_nxt;
      prio_r  <= prio_nxt;
      awf_r   <= awf_nxt;
      awa_r   <= awa_nxt;
      wf_r    <= wf_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      awrdy_r <= awrdy_nxt;
      wrdy_r  <= wrdy_nxt;
      bv_r    <= bv_nxt;
      br_r    <= br_nxt;
      arrdy_r <= arrdy_nxt;
      rv_r    <= rv_nxt;
      rr_r    <= rr_nxt;
      rd_r    <= rd_nxt;
    end
  end

  // Outputs straight from flops
  assign o_link_ready   = ready_r;
  assign o_irq_valid    = val_r;
  assign o_irq_targets  = tgt_r;
  assign o_irq_vector   = vec_r;
  assign o_irq_class    = cls_r;
  assign o_irq_level    = lvl_r;
  assign o_irq_msg_type = mt_r;
  assign o_irq_unit     = unit_r;
  assign s_axi_awready  = awrdy_r;
  assign s_axi_wready   = wrdy_r;
  assign s_axi_bvalid   = bv_r;
  assign s_axi_bresp    = br_r;
  assign s_axi_arready  = arrdy_r;
  assign s_axi_rvalid   = rv_r;
  assign s_axi_rdata    = rd_r;
  assign s_axi_rresp    = rr_r;

  // Checks on delivered requests
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset || !i_ce);

  a_arb_one_target: assert property (
    val_r && cls_r == xirq_pkg::CLS_ARB |-> $onehot0(tgt_r))
    else $error("arbitrated request sent to more than one target");
  a_fixed_bcast_all: assert property (
    val_r && cls_r == xirq_pkg::CLS_FIXED && !dm_r &&
    dst_r[7:0] == xirq_pkg::PHYS_BCAST |-> &tgt_r)
    else $error("fixed broadcast missed a target");
  a_phys_upper_zero: assert property (
    val_r && !dm_r |-> dst_r[31:8] == '0)
    else $error("physical request with nonzero upper target");
  a_nonvec_vector: assert property (
    val_r && cls_r == xirq_pkg::CLS_NONVEC |->
    vec_r == xirq_pkg::NONVEC_VEC && !lvl_r)
    else $error("non-vectored request with vector or level");
  a_class_legal: assert property (
    val_r |-> cls_r != xirq_pkg::CLS_BAD)
    else $error("request delivered with illegal class");
  a_valid_pulse: assert property (
    val_r |-> state_r == xirq_pkg::ST_HEAD && bt_r == '0 && ready_r
    ##1 !val_r)
    else $error("delivery not a single pulse after frame");
  a_prefix_match: assert property (
    val_r && ctrl_r[xirq_pkg::CTRL_CHK] |-> f_pfx == xirq_pkg::ADDR_PREFIX)
    else $error("request delivered with wrong address prefix");
  a_cmd_code: assert property (
    val_r |-> (f_cmd & xirq_pkg::CMD_MASK) == xirq_pkg::CMD_VAL)
    else $error("request delivered with wrong command");

endmodule

// >>> testbench/x86_interrupt_request_packet_tb_top.sv
// Self-checking bench for the interrupt request receiver
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module x86_interrupt_request_packet_tb_top;
  logic        i_mclk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, g;
  logic        i_link_valid, i_link_ctl, o_link_ready, o_irq_valid;
  logic        o_irq_level, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [7:0]  i_link_data, o_irq_vector;
  logic [3:0]  o_irq_targets, o_irq_msg_type, s_axi_wstrb = '0;
  logic [1:0]  o_irq_class, s_axi_bresp, s_axi_rresp, r;
  logic [4:0]  o_irq_unit;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  int          fails = 0, checked = 0, cyc = 0;

  xirq_link_src src (.i_mclk, .i_ready(o_link_ready), .o_valid(i_link_valid),
                     .o_ctl(i_link_ctl), .o_data(i_link_data));
  xirq_receiver #(.NUM_DEST(4)) dut (.i_mclk, .i_reset, .i_ce, .i_link_valid,
    .i_link_ctl, .i_link_data, .o_link_ready, .o_irq_valid, .o_irq_targets,
    .o_irq_vector, .o_irq_class, .o_irq_level, .o_irq_msg_type, .o_irq_unit,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  // 40 MHz clock
  initial forever #12.5 i_mclk = ~i_mclk;

  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw;
    @(posedge i_mclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    s_axi_awaddr <= a;
    s_axi_wdata  <= v;
    s_axi_wstrb  <= 4'hf;
    @(negedge i_mclk);
    while (s_axi_awvalid || s_axi_wvalid) begin
      ta = s_axi_awready;
      tw = s_axi_wready;
      @(posedge i_mclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      @(negedge i_mclk);
    end
    while (s_axi_bvalid !== 1'b1) @(negedge i_mclk);
    r = s_axi_bresp;
    @(posedge i_mclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge i_mclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do @(negedge i_mclk); while (s_axi_arready !== 1'b1);
    @(posedge i_mclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge i_mclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge i_mclk);
    s_axi_rready <= 1'b0;
  endtask

  // Send one packet and watch a few cycles for the delivery pulse
  task automatic pkt(input logic [7:0] t3, input logic [31:0] dst,
                     input logic [7:0] vec, input logic [15:0] pfx);
    g = 1'b0;
    src.send(t3, dst, vec, pfx);
    repeat (6) begin
      @(negedge i_mclk);
      if (o_irq_valid === 1'b1) g = 1'b1;
    end
  endtask

  task automatic t_fixed;
    pkt(8'h00, 32'h0000_00ff, 8'h41, 16'hfdf8);
    `CHK(g, 1'b1)
    `CHK(o_irq_targets, 4'hf)
    `CHK(o_irq_class, xirq_pkg::CLS_FIXED)
    `CHK(o_irq_vector, 8'h41)
    `CHK(o_irq_unit, 5'h03)
    axi_wr(xirq_pkg::OFF_PHYS + 12'h004, 32'h0000_0002);
    `CHK(r, xirq_pkg::RESP_OKAY)
    pkt(8'h00, 32'h0000_0002, 8'h42, 16'hfdf8);
    `CHK(o_irq_targets, 4'h2)
    axi_wr(xirq_pkg::OFF_LOG + 12'h00c, 32'h0000_0100);
    pkt(8'h40, 32'h0000_0100, 8'h43, 16'hfdf8);
    `CHK(o_irq_targets, 4'h8)
  endtask

  task automatic t_arb;
    axi_wr(xirq_pkg::OFF_PRIO, 32'h0000_0005);
    pkt(8'h04, 32'h0000_00ff, 8'h52, 16'hfdf8);
    `CHK(o_irq_class, xirq_pkg::CLS_ARB)
    `CHK(o_irq_targets, 4'h2)
    // Focus target keeps the vector though no longer lowest
    axi_wr(xirq_pkg::OFF_PRIO + 12'h004, 32'h0000_0009);
    pkt(8'h04, 32'h0000_00ff, 8'h52, 16'hfdf8);
    `CHK(o_irq_targets, 4'h2)
  endtask

  // Level then edge on one vector; the edge packet is refused
  task automatic t_trig;
    pkt(8'h20, 32'h0000_00ff, 8'h60, 16'hfdf8);
    `CHK(o_irq_level, 1'b1)
    pkt(8'h00, 32'h0000_00ff, 8'h60, 16'hfdf8);
    `CHK(g, 1'b0)
  endtask

  task automatic t_nonvec;
    pkt(8'h08, 32'h0000_00ff, 8'h00, 16'hfdf8);
    `CHK(o_irq_class, xirq_pkg::CLS_NONVEC)
    `CHK(o_irq_msg_type, xirq_pkg::MT_SMI)
    // Legacy external controller request, also non-vectored
    pkt(8'h98, 32'h0000_00ff, 8'h00, 16'hfdf8);
    `CHK(o_irq_msg_type, xirq_pkg::MT_LEXT)
    `CHK(o_irq_class, xirq_pkg::CLS_NONVEC)
    pkt(8'h08, 32'h0000_00ff, 8'h05, 16'hfdf8);
    `CHK(g, 1'b0)
    pkt(8'h28, 32'h0000_00ff, 8'h00, 16'hfdf8);
    `CHK(g, 1'b0)
  endtask

  task automatic t_refuse;
    pkt(8'h00, 32'h0000_00ff, 8'h70, 16'hfdf9);
    `CHK(g, 1'b0)
    axi_rd(xirq_pkg::OFF_STATUS);
    `CHK(d[xirq_pkg::ERR_PREFIX], 1'b1)
    pkt(8'h00, 32'h0000_0100, 8'h71, 16'hfdf8);
    `CHK(g, 1'b0)
    axi_rd(12'h0fc);
    `CHK(r, xirq_pkg::RESP_SLVERR)
  endtask

  // Hang guard: the scenarios need well under this many cycles
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      complete_run();
    end
  end

  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_mclk);
    t_fixed();
    t_arb();
    t_trig();
    t_nonvec();
    t_refuse();
    complete_run();
  end
endmodule

// >>> testbench/xirq_link_src.sv
// Link sender model: frames interrupt request packets beat by beat
`timescale 1ns/100ps
module xirq_link_src (
  // Clock
  input  wire logic       i_mclk,
  // Link beats
  input  wire logic       i_ready,
  output logic            o_valid,
  output logic            o_ctl,
  output logic [7:0]      o_data
);
  logic [7:0] b [12];

  // Quiet link at time zero
  initial begin
    o_valid = 1'b0;
    o_ctl   = 1'b0;
    o_data  = 8'h00;
  end

  // Whole packet; each beat held until ready is seen at its edge
  task automatic send(input logic [7:0] t3, input logic [31:0] dst,
                      input logic [7:0] vec, input logic [15:0] pfx);
    b = '{8'h29, 8'h03, 8'h00, t3, dst[7:0], vec, pfx[7:0], pfx[15:8],
          dst[15:8], dst[23:16], dst[31:24], 8'h00};
    @(posedge i_mclk);
    for (int k = 0; k < 12; k++) begin
      o_valid <= 1'b1;
      o_ctl   <= (k < 8);
      o_data  <= b[k];
      do @(negedge i_mclk); while (i_ready !== 1'b1);
      @(posedge i_mclk);
    end
    // Released byte inverted so a stale value cannot match
    o_valid <= 1'b0;
    o_ctl   <= 1'b0;
    o_data  <= ~b[11];
  endtask
endmodule
